// ===== verilog/aks_top.sv
// Frame-type classifier and key selector for the second-stage ACL match
//
// Overview of operation
// - Every frame gets exactly one of nine types
// - IPv6 by type and version; FF00::/8 is multicast
// - IPv6 next header gives TCP, UDP or other
// - IPv4 by type and version; 224.0.0.0/4 multicast
// - IPv4 protocol gives TCP, UDP or other
// - Types 0x0806 and 0x8035 are address resolution
// - Type 0x8902 is an OAM frame
// - Length below 0x600 with AA, AA, 03 is SNAP
// - Length below 0x600 otherwise is LLC
// - Other types from 0x600 are generic frames
// - Generic frame with type 0x88F7 is PTP
// - UDP to port 319 or 320 is PTP
// - PTP carries eight payload bytes extracted
// - Key and match only for enabled port lookups
// - Key choice is per port per lookup
// - OAM, SNAP, LLC, generic use MAC key unless custom key requested
// - IPv6 and address resolution allow listed keys
// - IPv4 multicast allows five listed keys
// - IPv4 unicast allows four keys, no VLAN key
// - Upstream custom key request overrides port choice
`timescale 1ns/1ps
module aks_top #(
  parameter int unsigned NPORT = aks_pkg::NPORT_DEF
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  input  wire aks_pkg::aks_hdr_s           i_hdr,
  output aks_pkg::aks_res_s                o_res,
  input  wire logic [aks_pkg::ADDR_W-1:0]  i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [31:0]                 i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic [31:0]                      o_avs_readdata,
  output logic                             o_avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    aks_pkg::aks_cfg_s [NPORT-1:0] cfg;
    logic                          ack;
    logic [31:0]                   rdata;
    logic [15:0]                   count;
    aks_pkg::aks_ftype_e           last;
    aks_pkg::aks_res_s             res;
  } aks_state_s;

  aks_state_s s_q;
  aks_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Frame classification

  aks_pkg::aks_ftype_e             ftype;
  aks_pkg::aks_sub_e               sub;
  logic                            ptp;
  logic [aks_pkg::PTP_W-1:0]       ptp_data;
  logic                            is_ip6;
  logic                            is_ip4;
  logic                            is_len;
  logic                            is_snap;

  always_comb begin
    is_ip6  = (i_hdr.tl == aks_pkg::TL_IPV6) &&
              (i_hdr.ip_ver == aks_pkg::IPV6_VER);
    is_ip4  = (i_hdr.tl == aks_pkg::TL_IPV4) &&
              (i_hdr.ip_ver == aks_pkg::IPV4_VER);
    is_len  = (i_hdr.tl < aks_pkg::TL_MIN_GENERIC_ETHERTYPE_FRAME);
    is_snap = (i_hdr.dsap == aks_pkg::SAP_SNAP) &&
              (i_hdr.ssap == aks_pkg::SAP_SNAP) &&
              (i_hdr.ctrl == aks_pkg::CTRL_SNAP);
    // One chain, first hit wins, so overlapping checks cannot both fire
    if (is_ip6) begin
      ftype = (i_hdr.ip6_dst_top == aks_pkg::IPV6_MC_TOP) ?
              aks_pkg::FT_IP6_MC : aks_pkg::FT_IP6_UC;
    end else if (is_ip4) begin
      ftype = (i_hdr.ip4_dst_top[7:4] == aks_pkg::IPV4_MC_TOP) ?
              aks_pkg::FT_IP4_MC : aks_pkg::FT_IP4_UC;
    end else if ((i_hdr.tl == aks_pkg::TL_ARP) ||
                 (i_hdr.tl == aks_pkg::TL_RARP)) begin
      ftype = aks_pkg::FT_ARP;
    end else if (i_hdr.tl == aks_pkg::TL_OAM) begin
      ftype = aks_pkg::FT_OAM;
    end else if (is_len && is_snap) begin
      ftype = aks_pkg::FT_SNAP;
    end else if (is_len) begin
      ftype = aks_pkg::FT_LLC;
    end else begin
      // Includes IP type values whose version field disagrees
      ftype = aks_pkg::FT_GENERIC_ETHERTYPE_FRAME;
    end
  end

  always_comb begin
    if (is_ip6 || is_ip4) begin
      if (i_hdr.l4_proto == aks_pkg::PROTO_TCP) begin
        sub = aks_pkg::SUB_TCP;
      end else if (i_hdr.l4_proto == aks_pkg::PROTO_UDP) begin
        sub = aks_pkg::SUB_UDP;
      end else begin
        sub = aks_pkg::SUB_OTHER;
      end
    end else begin
      sub = aks_pkg::SUB_NONE;
    end
  end

  always_comb begin
    ptp      = 1'b0;
    ptp_data = '0;
    if ((ftype == aks_pkg::FT_GENERIC_ETHERTYPE_FRAME) && (i_hdr.tl == aks_pkg::TL_PTP)) begin
      ptp      = 1'b1;
      ptp_data = i_hdr.generic_ethertype_frame_pay;
    end else if ((sub == aks_pkg::SUB_UDP) &&
                 ((i_hdr.udp_dport == aks_pkg::PTP_EVT_PORT) ||
                  (i_hdr.udp_dport == aks_pkg::PTP_GEN_PORT))) begin
      ptp      = 1'b1;
      ptp_data = i_hdr.udp_pay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lookup key selection

  logic                                     port_ok;
  aks_pkg::aks_cfg_s                        port_cfg;
  aks_pkg::aks_lk_s [aks_pkg::NLOOKUP-1:0]  lk;

  always_comb begin
    port_ok  = (int'(i_hdr.port) < NPORT);
    port_cfg = '0;
    // Unknown ingress port behaves as if every lookup were off
    if (port_ok) begin
      port_cfg = s_q.cfg[i_hdr.port];
    end
  end

  genvar g;
  generate
    for (g = 0; g < aks_pkg::NLOOKUP; g++) begin : g_lk
      aks_key_pick u_pick (
        .i_ftype      (ftype),
        .i_ena        (port_cfg.ena[g]),
        .i_sel        (port_cfg.key[g]),
        .i_custom_ena (i_hdr.custom_ena),
        .i_custom_pos (i_hdr.custom_pos),
        .o_lk         (lk[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  logic                           req;
  logic [aks_pkg::ADDR_W-1:0]     off;
  logic                           port_hit;
  logic [aks_pkg::ADDR_W-3:0]     widx;
  logic [31:0]                    rd_val;

  always_comb begin
    req      = i_avs_read | i_avs_write;
    off      = i_avs_address - aks_pkg::REG_PORT_BASE;
    widx     = off[aks_pkg::ADDR_W-1:2];
    port_hit = (i_avs_address >= aks_pkg::REG_PORT_BASE) &&
               (off[1:0] == 2'h0) && (int'(widx) < NPORT);
    rd_val   = 32'h0000_0000;
    if (i_avs_address == aks_pkg::REG_STATUS) begin
      rd_val[aks_pkg::ST_CNT_LSB +: 16]  = s_q.count;
      rd_val[aks_pkg::ST_TYPE_LSB +: 4]  = s_q.last;
    end else if (port_hit) begin
      rd_val[aks_pkg::CFG_ENA_LSB +: aks_pkg::NLOOKUP] = s_q.cfg[widx].ena;
      rd_val[aks_pkg::CFG_KEY0_LSB +: aks_pkg::KEY_W]  = s_q.cfg[widx].key[0];
      rd_val[aks_pkg::CFG_KEY1_LSB +: aks_pkg::KEY_W]  = s_q.cfg[widx].key[1];
    end
  end

  // One wait cycle per access keeps read data registered
  assign o_avs_waitrequest = req & ~s_q.ack;
  assign o_avs_readdata    = s_q.rdata;
  assign o_res             = s_q.res;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d     = s_q;
    s_d.ack = req & ~s_q.ack;
    if (i_avs_read && !s_q.ack) begin
      s_d.rdata = rd_val;
    end
    // Write lands at the edge where waitrequest is seen low
    if (i_avs_write && s_q.ack && port_hit) begin
      if (i_avs_byteenable[0]) begin
        s_d.cfg[widx].ena = i_avs_writedata[aks_pkg::CFG_ENA_LSB +:
                                            aks_pkg::NLOOKUP];
        s_d.cfg[widx].key[0] = aks_pkg::aks_key_e'(
          i_avs_writedata[aks_pkg::CFG_KEY0_LSB +: aks_pkg::KEY_W]);
      end
      if (i_avs_byteenable[1]) begin
        s_d.cfg[widx].key[1] = aks_pkg::aks_key_e'(
          i_avs_writedata[aks_pkg::CFG_KEY1_LSB +: aks_pkg::KEY_W]);
      end
    end
    s_d.res.valid = i_hdr.valid;
    if (i_hdr.valid) begin
      s_d.count        = s_q.count + 16'h0001;
      s_d.last         = ftype;
      s_d.res.port     = i_hdr.port;
      s_d.res.ftype    = ftype;
      s_d.res.sub      = sub;
      s_d.res.ptp      = ptp;
      s_d.res.ptp_data = ptp_data;
      s_d.res.lk       = lk;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ip6_type;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl == aks_pkg::TL_IPV6) &&
    (i_hdr.ip_ver == aks_pkg::IPV6_VER) |=>
    o_res.valid && (o_res.ftype == (($past(i_hdr.ip6_dst_top) == 8'hff) ?
                    aks_pkg::FT_IP6_MC : aks_pkg::FT_IP6_UC));
  endproperty
  a_ip6_type: assert property (p_ip6_type)
    else $error("IPv6 frame typed wrongly");

  property p_ip4_sub;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl == aks_pkg::TL_IPV4) &&
    (i_hdr.ip_ver == aks_pkg::IPV4_VER) && (i_hdr.l4_proto == 8'h11) |=>
    (o_res.sub == aks_pkg::SUB_UDP) &&
    ((o_res.ftype == aks_pkg::FT_IP4_MC) ||
     (o_res.ftype == aks_pkg::FT_IP4_UC));
  endproperty
  a_ip4_sub: assert property (p_ip4_sub)
    else $error("IPv4 UDP subtype lost");

  property p_arp;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl == 16'h8035) |=>
    o_res.ftype == aks_pkg::FT_ARP;
  endproperty
  a_arp: assert property (p_arp)
    else $error("Reverse address resolution not typed");

  property p_oam;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl == 16'h8902) |=>
    (o_res.ftype == aks_pkg::FT_OAM) && (o_res.sub == aks_pkg::SUB_NONE);
  endproperty
  a_oam: assert property (p_oam)
    else $error("OAM frame not typed");

  property p_len_split;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl < 16'h0600) |=>
    (o_res.ftype == (($past(i_hdr.dsap) == 8'haa) &&
                     ($past(i_hdr.ssap) == 8'haa) &&
                     ($past(i_hdr.ctrl) == 8'h03) ?
                     aks_pkg::FT_SNAP : aks_pkg::FT_LLC));
  endproperty
  a_len_split: assert property (p_len_split)
    else $error("SNAP or LLC split wrong");

  property p_ptp_eth;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl == 16'h88f7) |=>
    o_res.ptp && (o_res.ftype == aks_pkg::FT_GENERIC_ETHERTYPE_FRAME) &&
    (o_res.ptp_data == $past(i_hdr.generic_ethertype_frame_pay));
  endproperty
  a_ptp_eth: assert property (p_ptp_eth)
    else $error("PTP over Ethernet missed");

  property p_mac_only;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_res.valid && (o_res.ftype >= aks_pkg::FT_OAM) |->
    (o_res.lk[0].key == aks_pkg::KEY_MAC_ETHERTYPE_KEY) ||
    (o_res.lk[0].key == aks_pkg::KEY_CUSTOM);
  endproperty
  a_mac_only: assert property (p_mac_only)
    else $error("Non-IP frame took a non-MAC key");

  property p_no_v4_vlan_uc;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_res.valid && (o_res.ftype == aks_pkg::FT_IP4_UC) |->
    (o_res.lk[1].key != aks_pkg::KEY_IP4_VLAN) &&
    (o_res.lk[0].key != aks_pkg::KEY_IP4_VLAN);
  endproperty
  a_no_v4_vlan_uc: assert property (p_no_v4_vlan_uc)
    else $error("IPv4 unicast took the VLAN key");

  property p_off_lookup;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && port_ok && !port_cfg.ena[1] |=>
    !o_res.lk[1].ena && (o_res.lk[1].key == aks_pkg::KEY_MAC_ETHERTYPE_KEY);
  endproperty
  a_off_lookup: assert property (p_off_lookup)
    else $error("Disabled lookup produced a key");

  property p_custom;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && i_hdr.custom_ena && port_cfg.ena[0] |=>
    (o_res.lk[0].key == aks_pkg::KEY_CUSTOM) &&
    (o_res.lk[0].custom_pos == $past(i_hdr.custom_pos));
  endproperty
  a_custom: assert property (p_custom)
    else $error("Custom key request ignored");

  property p_ip6_sub;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.tl == aks_pkg::TL_IPV6) &&
    (i_hdr.ip_ver == aks_pkg::IPV6_VER) && (i_hdr.l4_proto == 8'h06) |=>
    o_res.sub == aks_pkg::SUB_TCP;
  endproperty
  a_ip6_sub: assert property (p_ip6_sub)
    else $error("IPv6 TCP subtype lost");

  property p_ptp_udp;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_hdr.valid && (i_hdr.l4_proto == 8'h11) &&
    (((i_hdr.tl == aks_pkg::TL_IPV4) && (i_hdr.ip_ver == 4'h4)) ||
     ((i_hdr.tl == aks_pkg::TL_IPV6) && (i_hdr.ip_ver == 4'h6))) &&
    ((i_hdr.udp_dport == 16'h013f) || (i_hdr.udp_dport == 16'h0140)) |=>
    o_res.ptp && (o_res.ptp_data == $past(i_hdr.udp_pay));
  endproperty
  a_ptp_udp: assert property (p_ptp_udp)
    else $error("PTP over UDP missed");

  property p_bus_answer;
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_avs_waitrequest) |=> !o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus answer late");

endmodule : aks_top

// ===== verilog/aks_pkg.sv
// Shared constants, types and register map of the ACL key selector
package aks_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Header field values
  localparam logic [15:0] TL_IPV6      = 16'h86dd;
  localparam logic [15:0] TL_IPV4      = 16'h0800;
  localparam logic [15:0] TL_ARP       = 16'h0806;
  localparam logic [15:0] TL_RARP      = 16'h8035;
  localparam logic [15:0] TL_OAM       = 16'h8902;
  localparam logic [15:0] TL_MIN_GENERIC_ETHERTYPE_FRAME = 16'h0600;
  localparam logic [15:0] TL_PTP       = 16'h88f7;
  localparam logic [3:0]  IPV6_VER     = 4'h6;
  localparam logic [3:0]  IPV4_VER     = 4'h4;
  localparam logic [7:0]  IPV6_MC_TOP  = 8'hff;
  localparam logic [3:0]  IPV4_MC_TOP  = 4'he;
  localparam logic [7:0]  PROTO_TCP    = 8'h06;
  localparam logic [7:0]  PROTO_UDP    = 8'h11;
  localparam logic [7:0]  SAP_SNAP     = 8'haa;
  localparam logic [7:0]  CTRL_SNAP    = 8'h03;
  localparam logic [15:0] PTP_EVT_PORT = 16'h013f;
  localparam logic [15:0] PTP_GEN_PORT = 16'h0140;

  //////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned NPORT_DEF = 8;
  localparam int unsigned NLOOKUP   = 2;
  localparam int unsigned PTP_BYTES = 8;
  localparam int unsigned PTP_W     = 8 * PTP_BYTES;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned KEY_W     = 3;

  //////////////////////////////////////////////////////////////////////////
  // Register map and field positions
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_PORT_BASE = 8'h40;
  localparam int unsigned ST_CNT_LSB    = 0;
  localparam int unsigned ST_TYPE_LSB   = 16;
  localparam int unsigned CFG_ENA_LSB   = 0;
  localparam int unsigned CFG_KEY0_LSB  = 4;
  localparam int unsigned CFG_KEY1_LSB  = 8;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    FT_IP6_MC = 4'h0,
    FT_IP6_UC = 4'h1,
    FT_IP4_MC = 4'h2,
    FT_IP4_UC = 4'h3,
    FT_ARP    = 4'h4,
    FT_OAM    = 4'h5,
    FT_SNAP   = 4'h6,
    FT_LLC    = 4'h7,
    FT_GENERIC_ETHERTYPE_FRAME  = 4'h8
  } aks_ftype_e;

  typedef enum logic [1:0] {
    SUB_NONE  = 2'h0,
    SUB_TCP   = 2'h1,
    SUB_UDP   = 2'h2,
    SUB_OTHER = 2'h3
  } aks_sub_e;

  typedef enum logic [2:0] {
    KEY_MAC_ETHERTYPE_KEY   = 3'h0,
    KEY_ARP         = 3'h1,
    KEY_IP4_VLAN    = 3'h2,
    KEY_IP6_VLAN    = 3'h3,
    KEY_SEVEN_FIELD = 3'h4,
    KEY_IP4_PORT    = 3'h5,
    KEY_IP4_NONPORT = 3'h6,
    KEY_CUSTOM      = 3'h7
  } aks_key_e;

  typedef struct packed {
    logic                  valid;
    logic [PORT_W-1:0]     port;
    logic [15:0]           tl;
    logic [3:0]            ip_ver;
    logic [7:0]            ip6_dst_top;
    logic [7:0]            ip4_dst_top;
    logic [7:0]            l4_proto;
    logic [7:0]            dsap;
    logic [7:0]            ssap;
    logic [7:0]            ctrl;
    logic [15:0]           udp_dport;
    logic [PTP_W-1:0]      generic_ethertype_frame_pay;
    logic [PTP_W-1:0]      udp_pay;
    logic                  custom_ena;
    logic [1:0]            custom_pos;
  } aks_hdr_s;

  typedef struct packed {
    logic                  ena;
    aks_key_e              key;
    logic [1:0]            custom_pos;
  } aks_lk_s;

  typedef struct packed {
    logic                  valid;
    logic [PORT_W-1:0]     port;
    aks_ftype_e            ftype;
    aks_sub_e              sub;
    logic                  ptp;
    logic [PTP_W-1:0]      ptp_data;
    aks_lk_s [NLOOKUP-1:0] lk;
  } aks_res_s;

  typedef struct packed {
    logic     [NLOOKUP-1:0] ena;
    aks_key_e [NLOOKUP-1:0] key;
  } aks_cfg_s;

endpackage : aks_pkg

// ===== verilog/aks_key_pick.sv
// Per-lookup key resolution from frame type and port choice
`timescale 1ns/1ps
module aks_key_pick (
  input  wire aks_pkg::aks_ftype_e i_ftype,
  input  wire logic                i_ena,
  input  wire aks_pkg::aks_key_e   i_sel,
  input  wire logic                i_custom_ena,
  input  wire logic [1:0]          i_custom_pos,
  output aks_pkg::aks_lk_s         o_lk
);

  logic allowed;

  always_comb begin
    allowed = 1'b0;
    case (i_ftype)
      aks_pkg::FT_IP6_MC: begin
        allowed = (i_sel == aks_pkg::KEY_IP6_VLAN) ||
                  (i_sel == aks_pkg::KEY_SEVEN_FIELD);
      end
      aks_pkg::FT_IP6_UC: begin
        allowed = (i_sel == aks_pkg::KEY_SEVEN_FIELD);
      end
      aks_pkg::FT_IP4_MC: begin
        allowed = (i_sel == aks_pkg::KEY_IP4_VLAN) ||
                  (i_sel == aks_pkg::KEY_SEVEN_FIELD) ||
                  (i_sel == aks_pkg::KEY_IP4_PORT) ||
                  (i_sel == aks_pkg::KEY_IP4_NONPORT);
      end
      aks_pkg::FT_IP4_UC: begin
        allowed = (i_sel == aks_pkg::KEY_SEVEN_FIELD) ||
                  (i_sel == aks_pkg::KEY_IP4_PORT) ||
                  (i_sel == aks_pkg::KEY_IP4_NONPORT);
      end
      aks_pkg::FT_ARP: begin
        allowed = (i_sel == aks_pkg::KEY_ARP);
      end
      // OAM, SNAP, LLC and generic frames know only the MAC key
      default: begin
        allowed = 1'b0;
      end
    endcase
  end

  always_comb begin
    o_lk            = '0;
    o_lk.ena        = i_ena;
    o_lk.key        = aks_pkg::KEY_MAC_ETHERTYPE_KEY;
    o_lk.custom_pos = 2'h0;
    if (!i_ena) begin
      o_lk.key = aks_pkg::KEY_MAC_ETHERTYPE_KEY;
    end else if (i_custom_ena) begin
      o_lk.key        = aks_pkg::KEY_CUSTOM;
      o_lk.custom_pos = i_custom_pos;
    end else if (allowed) begin
      o_lk.key = i_sel;
    end else begin
      o_lk.key = aks_pkg::KEY_MAC_ETHERTYPE_KEY;
    end
  end

endmodule : aks_key_pick

// ===== verif/aks_src.sv
// Upstream classifier stage model that presents one header per request
`timescale 1ns/1ps
module aks_src (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_go,
  input  wire aks_pkg::aks_hdr_s i_hdr,
  output aks_pkg::aks_hdr_s      o_hdr
);
  ////////////////////////////////////////////////////////////////////////
  // Idle cycles show inverted fields so stale data never passes as good
  aks_pkg::aks_hdr_s nxt;

  always_comb begin
    nxt       = i_go ? i_hdr : ~o_hdr;
    nxt.valid = i_go;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hdr <= '0;
    end else begin
      o_hdr <= nxt;
    end
  end
endmodule : aks_src

// ===== verif/aks_top_test.sv
// Self-checking bench for the ACL key selector
`timescale 1ns/1ps
module aks_top_test;
  localparam logic [63:0] EPAY = 64'h0123456789abcdef;
  localparam logic [63:0] UPAY = 64'hfedcba9876543210;
  logic              clk;
  logic              rst_b;
  logic              go;
  aks_pkg::aks_hdr_s req;
  aks_pkg::aks_hdr_s hdr;
  aks_pkg::aks_res_s res;
  logic [7:0]        addr;
  logic              rd;
  logic              wr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic [3:0]        be;
  logic              waitreq;
  int                miscompares;
  int                compares;
  int                nfr;
  logic [3:0]        last_ft;

  aks_src src (.i_clk(clk), .i_rst_b(rst_b), .i_go(go), .i_hdr(req),
               .o_hdr(hdr));
  aks_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_hdr(hdr), .o_res(res),
               .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
               .i_avs_writedata(wdata), .i_avs_byteenable(be),
               .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr    <= w;
    rd    <= !w;
    q     = 32'h0;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (!waitreq) begin
        q = rdata;
        break;
      end
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) begin
      miscompares++;
      close_out();
    end
  endtask : bus

  task automatic wr32(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask : wr32

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk("readdata", {32'h0, q}, {32'h0, exp});
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////
  // Ports 1 and 3 enable both lookups, port 4 only the first one
  task automatic frm(input logic [7:0] p, input logic [15:0] tl,
                     input logic [3:0] ver, input logic [7:0] dst, pr,
                     input logic [15:0] dp, input logic [23:0] llc,
                     input logic cu, input aks_pkg::aks_ftype_e ft,
                     input aks_pkg::aks_sub_e sb, input logic pt,
                     input aks_pkg::aks_key_e k0, k1);
    logic [1:0]        en;
    logic [63:0]       pd;
    aks_pkg::aks_key_e k;
    aks_pkg::aks_hdr_s h;
    en = (p == 8'h01 || p == 8'h03) ? 2'b11 : (p == 8'h04) ? 2'b01 : 2'b00;
    pd = !pt ? 64'h0 : (tl == aks_pkg::TL_PTP) ? EPAY : UPAY;
    h = '0;
    h.port = p;
    h.tl = tl;
    h.ip_ver = ver;
    h.ip6_dst_top = dst;
    h.ip4_dst_top = dst;
    h.l4_proto = pr;
    h.udp_dport = dp;
    {h.dsap, h.ssap, h.ctrl} = llc;
    h.generic_ethertype_frame_pay = EPAY;
    h.udp_pay = UPAY;
    h.custom_ena = cu;
    h.custom_pos = 2'h2;
    @(posedge clk);
    req <= h;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk("valid", res.valid, 1'b1);
    chk("port", res.port, p);
    chk("ftype", res.ftype, ft);
    chk("sub", res.sub, sb);
    chk("ptp", res.ptp, pt);
    chk("ptp_data", res.ptp_data, pd);
    for (int l = 0; l < 2; l++) begin
      k = !en[l] ? aks_pkg::KEY_MAC_ETHERTYPE_KEY : cu ? aks_pkg::KEY_CUSTOM
        : (l == 1) ? k1 : k0;
      chk("lk_ena", res.lk[l].ena, en[l]);
      chk("lk_key", res.lk[l].key, k);
      chk("lk_pos", res.lk[l].custom_pos,
          (cu && en[l]) ? 2'h2 : 2'h0);
    end
    @(posedge clk);
    #1;
    chk("valid_end", res.valid, 1'b0);
    nfr++;
    last_ft = ft;
  endtask : frm

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    req = '0;
    addr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    miscompares = 0;
    compares = 0;
    nfr = 0;
    last_ft = 4'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'h44, 32'h0);
    wr32(8'h54, 32'hffffffff, 4'hf);
    rd_chk(8'h54, 32'h00000773);
    wr32(8'h54, 32'h0, 4'h1);
    rd_chk(8'h54, 32'h00000700);
    wr32(8'h00, 32'hffffffff, 4'hf);
    rd_chk(8'h00, 32'h0);
    wr32(8'h60, 32'hffffffff, 4'hf);
    rd_chk(8'h60, 32'h0);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h45, 32'h0);
    wr32(8'h44, 32'h00000243, 4'hf);
    wr32(8'h4c, 32'h00000613, 4'hf);
    wr32(8'h50, 32'h00000051, 4'hf);
    $display("register tests done");
    frm(1, 16'h86dd, 6, 8'hff, 8'h06, 0, 0, 0, aks_pkg::FT_IP6_MC,
        aks_pkg::SUB_TCP, 0, aks_pkg::KEY_SEVEN_FIELD,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h86dd, 6, 8'hfe, 8'h11, 16'h013f, 0, 0, aks_pkg::FT_IP6_UC,
        aks_pkg::SUB_UDP, 1, aks_pkg::KEY_SEVEN_FIELD,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h0800, 4, 8'he0, 8'h11, 16'h0140, 0, 0, aks_pkg::FT_IP4_MC,
        aks_pkg::SUB_UDP, 1, aks_pkg::KEY_SEVEN_FIELD,
        aks_pkg::KEY_IP4_VLAN);
    frm(1, 16'h0800, 4, 8'hdf, 8'h2f, 0, 0, 0, aks_pkg::FT_IP4_UC,
        aks_pkg::SUB_OTHER, 0, aks_pkg::KEY_SEVEN_FIELD,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(3, 16'h0800, 4, 8'h0a, 8'h06, 16'h013f, 0, 0, aks_pkg::FT_IP4_UC,
        aks_pkg::SUB_TCP, 0, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_IP4_NONPORT);
    frm(3, 16'h0806, 0, 0, 0, 0, 0, 0, aks_pkg::FT_ARP,
        aks_pkg::SUB_NONE, 0, aks_pkg::KEY_ARP,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(3, 16'h8035, 0, 0, 0, 0, 0, 0, aks_pkg::FT_ARP,
        aks_pkg::SUB_NONE, 0, aks_pkg::KEY_ARP,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(3, 16'h8902, 0, 0, 0, 0, 0, 0, aks_pkg::FT_OAM,
        aks_pkg::SUB_NONE, 0, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h05ff, 0, 0, 0, 0, 24'haaaa03, 0, aks_pkg::FT_SNAP,
        aks_pkg::SUB_NONE, 0, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h05ff, 0, 0, 0, 0, 24'haaaa02, 0, aks_pkg::FT_LLC,
        aks_pkg::SUB_NONE, 0, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h88f7, 0, 0, 0, 0, 0, 0, aks_pkg::FT_GENERIC_ETHERTYPE_FRAME,
        aks_pkg::SUB_NONE, 1, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h86dd, 4, 8'hff, 8'h06, 0, 0, 0, aks_pkg::FT_GENERIC_ETHERTYPE_FRAME,
        aks_pkg::SUB_NONE, 0, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(2, 16'h0800, 4, 8'he0, 8'h06, 0, 0, 0, aks_pkg::FT_IP4_MC,
        aks_pkg::SUB_TCP, 0, aks_pkg::KEY_MAC_ETHERTYPE_KEY,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(4, 16'h0800, 4, 8'h0a, 8'h06, 0, 0, 0, aks_pkg::FT_IP4_UC,
        aks_pkg::SUB_TCP, 0, aks_pkg::KEY_IP4_PORT,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    frm(1, 16'h0800, 4, 8'h0a, 8'h11, 16'h013f, 0, 1, aks_pkg::FT_IP4_UC,
        aks_pkg::SUB_UDP, 1, aks_pkg::KEY_SEVEN_FIELD,
        aks_pkg::KEY_IP4_VLAN);
    // Port 3 now picks the IPv6 VLAN key and a custom code for lookup 1
    wr32(8'h4c, 32'h00000733, 4'hf);
    rd_chk(8'h4c, 32'h00000733);
    frm(3, 16'h86dd, 6, 8'hff, 8'h11, 16'h0050, 0, 0, aks_pkg::FT_IP6_MC,
        aks_pkg::SUB_UDP, 0, aks_pkg::KEY_IP6_VLAN,
        aks_pkg::KEY_MAC_ETHERTYPE_KEY);
    $display("frame tests done");
    rd_chk(8'h00, {12'h0, last_ft, nfr[15:0]});
    $display("status test done");
    close_out();
  end
endmodule : aks_top_test
